// ===== design/tx_status_pkg.sv
// package for the transmit tune and audio quality status block
// assumes one clock domain and a byte-wide command port
package tx_status_pkg;
	// opcodes
	localparam logic [7:0] OPC_TUNE_STATUS = 8'h33;
	localparam logic [7:0] OPC_AQ_STATUS = 8'h34;
	// reply lengths, status byte excluded
	localparam logic [3:0] TUNE_RESP_LEN = 4'h7;
	localparam logic [3:0] AQ_RESP_LEN = 4'h4;
	// status byte fields
	localparam int ST_CTS = 7;
	localparam int ST_ERR = 6;
	localparam int ST_AQ_IRQ = 1;
	localparam int ST_TUNE_IRQ = 0;
	// audio quality response byte one fields
	localparam int AQ_OVERMODULATION_FLAG = 2;
	localparam int AQ_HIGH = 1;
	localparam int AQ_LOW = 0;
	// argument fields
	localparam int ARG_ACK = 0;
	localparam logic [7:0] ARG_RSVD_MASK = 8'hFE;
	// register port offsets
	localparam logic [3:0] ADDR_CMD = 4'h0;
	localparam logic [3:0] ADDR_ARG = 4'h1;
	localparam logic [3:0] ADDR_RESP = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_IEN = 4'h4;
	localparam logic [3:0] ADDR_LOW_TH = 4'h5;
	localparam logic [3:0] ADDR_HIGH_TH = 4'h6;
	localparam logic [3:0] ADDR_LOW_DUR = 4'h7;
	localparam logic [3:0] ADDR_HIGH_DUR = 4'h8;
	// reset values
	localparam logic [7:0] LOW_TH_RESET = 8'hCE;
	localparam logic [7:0] HIGH_TH_RESET = 8'h00;
	localparam logic [15:0] DUR_RESET = 16'h0000;
	localparam logic [1:0] IEN_RESET = 2'h0;

	typedef struct packed {
		logic [15:0] freq;
		logic [7:0] out_level;
		logic [7:0] antcap;
		logic [7:0] noise;
		logic noise_valid;
	} tune_info_type;

	typedef struct packed {
		logic [7:0] level;
		logic overmodulation_flag;
	} audio_in_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARG = 2'b01,
		ST_REPLY = 2'b11
	} cmd_state_type;
endpackage

// ===== design/tx_status_block.sv
// command interpreter for tune status and audio quality status
// assumes host waits for clear-to-send; audio and tune info synchronous
//
// Functional notes
// - tune status takes one argument; reply is status plus seven bytes
// - tune status acknowledge bit clears seek/tune complete indicator
// - invalid argument sets error bit in status byte
// - reply bytes two and three carry tuned frequency high and low
// - reply byte five carries output voltage setting
// - reply byte six carries antenna capacitor value
// - reply byte seven carries last noise measure, zero if none
// - audio status opcode 34h, one argument, status plus four bytes
// - low flag set when audio stays below low threshold
// - high flag set when audio stays above high threshold
// - detection only after condition outlasts the configured duration
// - overmodulation flag set while overmodulation input is high
// - audio interrupt bit set when any of the three flags set
// - audio interrupt routable to hardware interrupt output by enable
// - clearing low or high flag rearms its duration counter
// - acknowledge zero keeps flags; one clears all three and interrupt
// - reply byte one: overmodulation_flag bit2, high bit1, low bit0
// - reply byte four returns input level, two's complement dBfs
// - counters run and status valid only after a tune command
// - clear-to-send set when next command may be accepted
`timescale 1ns/1ns
module tx_status_block
	import tx_status_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire tx_status_pkg::tune_info_type tune_info,
	input wire tx_status_pkg::audio_in_type audio_in,
	input wire logic tune_done,
	input wire logic tune_cmd_done,
	input wire logic powered_up,
	output logic irq_out
);
	import tx_status_pkg::*;

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	cmd_state_type state_reg;
	logic [7:0] opcode_reg;
	logic [7:0] resp_reg [0:7];
	logic [3:0] resp_len_reg;
	logic [3:0] resp_idx_reg;
	logic cts_reg;
	logic err_reg;
	logic seek_tune_done_irq_reg;
	logic overmodulation_flag_reg;
	logic input_level_high_flag_reg;
	logic input_level_low_flag_reg;
	logic armed_reg;
	logic [1:0] interrupt_enable_setting_reg;
	logic [7:0] low_threshold_setting_reg;
	logic [7:0] high_threshold_setting_reg;
	logic [15:0] low_duration_setting_reg;
	logic [15:0] high_duration_setting_reg;
	logic [15:0] low_cnt_reg;
	logic [15:0] high_cnt_reg;
	logic low_fired_reg;
	logic high_fired_reg;

	logic cmd_wr, arg_wr, ack, aq_ack, tune_ack, bad_arg;
	logic audio_quality_irq;
	logic low_hit, high_hit;
	logic below, above;

	assign cmd_wr = wr && addr == ADDR_CMD && cts_reg;
	assign arg_wr = wr && addr == ADDR_ARG && state_reg == ST_ARG;
	assign bad_arg = (wdata & ARG_RSVD_MASK) != 8'h00;
	assign ack = arg_wr && !bad_arg && wdata[ARG_ACK];
	assign aq_ack = ack && opcode_reg == OPC_AQ_STATUS;
	assign tune_ack = ack && opcode_reg == OPC_TUNE_STATUS;
	assign audio_quality_irq = overmodulation_flag_reg |
		input_level_high_flag_reg | input_level_low_flag_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			opcode_reg <= 8'h00;
			cts_reg <= 1'b1;
			err_reg <= 1'b0;
			resp_len_reg <= 4'h0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (cmd_wr) begin
						opcode_reg <= wdata;
						cts_reg <= 1'b0;
						err_reg <= 1'b0;
						if ((wdata == OPC_TUNE_STATUS ||
							wdata == OPC_AQ_STATUS) && powered_up) begin
							state_reg <= ST_ARG;
						end else begin
							err_reg <= 1'b1;
							cts_reg <= 1'b1;
						end
					end
				end
				ST_ARG: begin
					if (arg_wr) begin
						state_reg <= ST_REPLY;
						cts_reg <= 1'b1;
						if (bad_arg) begin
							err_reg <= 1'b1;
							resp_len_reg <= 4'h0;
						end else if (opcode_reg == OPC_TUNE_STATUS) begin
							resp_len_reg <= TUNE_RESP_LEN;
						end else begin
							resp_len_reg <= AQ_RESP_LEN;
						end
					end
				end
				ST_REPLY: begin
					if (cmd_wr) begin
						state_reg <= ST_IDLE;
						opcode_reg <= wdata;
						cts_reg <= 1'b0;
						err_reg <= 1'b0;
						if ((wdata == OPC_TUNE_STATUS ||
							wdata == OPC_AQ_STATUS) && powered_up) begin
							state_reg <= ST_ARG;
						end else begin
							err_reg <= 1'b1;
							cts_reg <= 1'b1;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
					cts_reg <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// reply capture
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 8; i++) begin
				resp_reg[i] <= 8'h00;
			end
		end else if (arg_wr && !bad_arg) begin
			for (int i = 0; i < 8; i++) begin
				resp_reg[i] <= 8'h00;
			end
			if (opcode_reg == OPC_TUNE_STATUS) begin
				resp_reg[2] <= tune_info.freq[15:8];
				resp_reg[3] <= tune_info.freq[7:0];
				resp_reg[5] <= tune_info.out_level;
				resp_reg[6] <= tune_info.antcap;
				resp_reg[7] <= tune_info.noise_valid ?
					tune_info.noise : 8'h00;
			end else begin
				resp_reg[1][AQ_OVERMODULATION_FLAG] <= overmodulation_flag_reg;
				resp_reg[1][AQ_HIGH] <= input_level_high_flag_reg;
				resp_reg[1][AQ_LOW] <= input_level_low_flag_reg;
				resp_reg[4] <= armed_reg ? audio_in.level : 8'h00;
			end
		end
	end

	// ----------------------------------------
	// audio level detection
	// ----------------------------------------
	assign below = $signed(audio_in.level) < $signed(low_threshold_setting_reg);
	assign above = $signed(audio_in.level) > $signed(high_threshold_setting_reg);
	// one set event per detection interval
	assign low_hit = below && !low_fired_reg && low_cnt_reg != 16'h0000 &&
		low_cnt_reg >= low_duration_setting_reg;
	assign high_hit = above && !high_fired_reg && high_cnt_reg != 16'h0000 &&
		high_cnt_reg >= high_duration_setting_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			armed_reg <= 1'b0;
		end else if (tune_cmd_done) begin
			armed_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			low_cnt_reg <= 16'h0000;
		end else if (!armed_reg || !below || aq_ack) begin
			low_cnt_reg <= 16'h0000;
		end else if (low_cnt_reg != 16'hFFFF) begin
			low_cnt_reg <= low_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			high_cnt_reg <= 16'h0000;
		end else if (!armed_reg || !above || aq_ack) begin
			high_cnt_reg <= 16'h0000;
		end else if (high_cnt_reg != 16'hFFFF) begin
			high_cnt_reg <= high_cnt_reg + 16'h0001;
		end
	end

	// ----------------------------------------
	// detection interval tracking
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			low_fired_reg <= 1'b0;
		end else if (!armed_reg || !below || aq_ack) begin
			low_fired_reg <= 1'b0;
		end else if (low_hit) begin
			low_fired_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			high_fired_reg <= 1'b0;
		end else if (!armed_reg || !above || aq_ack) begin
			high_fired_reg <= 1'b0;
		end else if (high_hit) begin
			high_fired_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// sticky flags, set wins over acknowledge
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			input_level_low_flag_reg <= 1'b0;
		end else if (armed_reg && low_hit) begin
			input_level_low_flag_reg <= 1'b1;
		end else if (aq_ack) begin
			input_level_low_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			input_level_high_flag_reg <= 1'b0;
		end else if (armed_reg && high_hit) begin
			input_level_high_flag_reg <= 1'b1;
		end else if (aq_ack) begin
			input_level_high_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			overmodulation_flag_reg <= 1'b0;
		end else if (armed_reg && audio_in.overmodulation_flag) begin
			overmodulation_flag_reg <= 1'b1;
		end else if (aq_ack) begin
			overmodulation_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			seek_tune_done_irq_reg <= 1'b0;
		end else if (tune_done) begin
			seek_tune_done_irq_reg <= 1'b1;
		end else if (tune_ack) begin
			seek_tune_done_irq_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// settings
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			interrupt_enable_setting_reg <= IEN_RESET;
			low_threshold_setting_reg <= LOW_TH_RESET;
			high_threshold_setting_reg <= HIGH_TH_RESET;
			low_duration_setting_reg <= DUR_RESET;
			high_duration_setting_reg <= DUR_RESET;
		end else if (wr) begin
			case (addr)
				ADDR_IEN: interrupt_enable_setting_reg <= wdata[1:0];
				ADDR_LOW_TH: low_threshold_setting_reg <= wdata;
				ADDR_HIGH_TH: high_threshold_setting_reg <= wdata;
				ADDR_LOW_DUR: low_duration_setting_reg <=
					{low_duration_setting_reg[7:0], wdata};
				ADDR_HIGH_DUR: high_duration_setting_reg <=
					{high_duration_setting_reg[7:0], wdata};
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// read port and interrupt output
	// ----------------------------------------
	logic [7:0] status_byte;
	always_comb begin
		status_byte = 8'h00;
		status_byte[ST_CTS] = cts_reg;
		status_byte[ST_ERR] = err_reg;
		status_byte[ST_AQ_IRQ] = audio_quality_irq;
		status_byte[ST_TUNE_IRQ] = seek_tune_done_irq_reg;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			resp_idx_reg <= 4'h0;
		end else if (arg_wr) begin
			resp_idx_reg <= 4'h1;
		end else if (rd && addr == ADDR_RESP && state_reg == ST_REPLY &&
			resp_idx_reg <= resp_len_reg) begin
			resp_idx_reg <= resp_idx_reg + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else if (rd) begin
			case (addr)
				ADDR_STATUS: rdata <= status_byte;
				ADDR_RESP: rdata <= (state_reg == ST_REPLY &&
					resp_idx_reg <= resp_len_reg) ?
					resp_reg[resp_idx_reg[2:0]] : 8'h00;
				ADDR_IEN: rdata <= {6'h00, interrupt_enable_setting_reg};
				ADDR_LOW_TH: rdata <= low_threshold_setting_reg;
				ADDR_HIGH_TH: rdata <= high_threshold_setting_reg;
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= (interrupt_enable_setting_reg[1] & audio_quality_irq) |
				(interrupt_enable_setting_reg[0] & seek_tune_done_irq_reg);
		end
	end
endmodule

// ===== verif/tx_status_checker.sv
// checker for the tune and audio status command port
// assumes one clock domain, bound to the top module's ports
`timescale 1ns/1ns
module tx_status_checker
	import tx_status_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic powered_up,
	input wire logic irq_out
);
	logic [1:0] ien_reg;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ien_reg <= IEN_RESET;
		end else if (wr && addr == ADDR_IEN) begin
			ien_reg <= wdata[1:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_cmd;
		wr && addr == ADDR_CMD && powered_up &&
			(wdata == OPC_TUNE_STATUS || wdata == OPC_AQ_STATUS);
	endsequence
	sequence s_arg(bad);
		wr && addr == ADDR_ARG && (|(wdata & ARG_RSVD_MASK)) == bad;
	endsequence
	sequence s_rd(a);
		rd && addr == a;
	endsequence
	AST_RDATA_ZERO: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data not zero outside a read");
	AST_CTS_DONE: assert property (
		s_cmd ##1 s_arg(1'b0) ##1 s_rd(ADDR_STATUS)
		|=> rdata[ST_CTS] && !rdata[ST_ERR])
		else $error("clear-to-send missing after command");
	AST_ERR_ARG: assert property (
		s_cmd ##1 s_arg(1'b1) ##1 s_rd(ADDR_STATUS) |=> rdata[ST_ERR])
		else $error("error bit missing after bad argument");
	AST_ERR_EMPTY: assert property (
		s_cmd ##1 s_arg(1'b1) ##1 s_rd(ADDR_STATUS) ##2 s_rd(ADDR_RESP)
		|=> rdata == 8'h00)
		else $error("reply not empty after bad argument");
	AST_ERR_POWER: assert property (
		wr && addr == ADDR_CMD && !powered_up ##1 s_rd(ADDR_STATUS)
		|=> rdata[ST_ERR] && rdata[ST_CTS])
		else $error("error bit missing while powered down");
	AST_IRQ_AQ: assert property (
		rd && addr == ADDR_STATUS && ien_reg[1] ##1
		rdata[ST_AQ_IRQ] && ien_reg[1]
		|=> irq_out)
		else $error("audio interrupt not routed");
	AST_IRQ_TUNE: assert property (
		rd && addr == ADDR_STATUS && ien_reg[0] ##1
		rdata[ST_TUNE_IRQ] && ien_reg[0]
		|=> irq_out)
		else $error("tune interrupt not routed");
	AST_IRQ_OFF: assert property (ien_reg == 2'h0 [*3] |-> !irq_out)
		else $error("interrupt out while disabled");
endmodule

// ===== verif/host_model.sv
// host controller model driving the command port
// assumes its tasks are called from one bench process
`timescale 1ns/1ns
module host_model
	import tx_status_pkg::*;
(
	input wire logic clk,
	input wire logic [7:0] rdata,
	output logic [3:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd
);
	initial begin
		addr = ADDR_CMD;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	task automatic bus(input logic w, input logic r, input logic [3:0] a,
		input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
	endtask
	task automatic get(input logic [3:0] a, output logic [7:0] v);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
		#1 v = rdata;
	endtask
	// opcode, argument, then status for clear-to-send
	task automatic cmd(input logic [7:0] op, input logic [7:0] arg,
		output logic [7:0] st);
		bus(1'b1, 1'b0, ADDR_CMD, op);
		bus(1'b1, 1'b0, ADDR_ARG, arg);
		get(ADDR_STATUS, st);
	endtask
endmodule

// ===== verif/testbench.sv
// top bench: clock, reset, scenarios and verdict
// assumes host_model drives the command port
`timescale 1ns/1ns
module testbench;
	import tx_status_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic tune_done = 1'b0;
	logic tune_cmd_done = 1'b0;
	logic powered_up = 1'b1;
	tune_info_type tune_info = '0;
	audio_in_type audio_in = '0;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, st, b;
	logic wr, rd, irq_out;
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	host_model i_host(.clk(clk), .rdata(rdata), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd));
	tx_status_block i_dut(.clk(clk), .resetn(resetn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.tune_info(tune_info), .audio_in(audio_in), .tune_done(tune_done),
		.tune_cmd_done(tune_cmd_done), .powered_up(powered_up),
		.irq_out(irq_out));
	// ----
	// shared tasks
	// ----
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_irq(input string n, input logic e);
		#1;
		total_checks++;
		if (irq_out !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, irq_out);
		end
	endtask
	task automatic complete_run();
		if (num_errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic idle(input int n);
		repeat (n) i_host.bus(1'b0, 1'b0, ADDR_CMD, 8'h00);
	endtask
	task automatic aq(input logic [7:0] arg, input logic [2:0] f,
		input logic [7:0] lv);
		i_host.cmd(OPC_AQ_STATUS, arg, st);
		chk("aq status", 8'h80, st & 8'hC0);
		if (!arg[0]) chk("aq irq", {7'h00, |f}, {7'h00, st[ST_AQ_IRQ]});
		i_host.get(ADDR_RESP, b);
		chk("aq flags", {5'h00, f}, b & 8'h07);
		repeat (3) i_host.get(ADDR_RESP, b);
		chk("aq level", lv, b);
		i_host.get(ADDR_RESP, b);
		chk("aq end", 8'h00, b);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_arm();
		idle(1);
		i_host.bus(1'b1, 1'b0, ADDR_LOW_DUR, 8'h00);
		i_host.bus(1'b1, 1'b0, ADDR_LOW_DUR, 8'h14);
		audio_in <= '{8'hC4, 1'b0};
		idle(30);
		aq(8'h00, 3'h0, 8'h00);
		idle(1);
		tune_cmd_done <= 1'b1;
		idle(1);
		tune_cmd_done <= 1'b0;
	endtask
	task automatic t_low();
		aq(8'h00, 3'h0, 8'hC4);
		idle(30);
		aq(8'h00, 3'h1, 8'hC4);
		i_host.bus(1'b1, 1'b0, ADDR_IEN, 8'h02);
		idle(3);
		chk_irq("aq irq out", 1'b1);
		aq(8'h01, 3'h1, 8'hC4);
		chk_irq("aq irq clr", 1'b0);
		aq(8'h00, 3'h0, 8'hC4);
		idle(30);
		aq(8'h00, 3'h1, 8'hC4);
		audio_in <= '{8'hEC, 1'b0};
		idle(30);
		aq(8'h00, 3'h1, 8'hEC);
		aq(8'h01, 3'h1, 8'hEC);
		i_host.bus(1'b1, 1'b0, ADDR_IEN, 8'h00);
	endtask
	task automatic t_high();
		idle(1);
		audio_in <= '{8'h05, 1'b1};
		idle(1);
		audio_in <= '{8'h05, 1'b0};
		idle(3);
		aq(8'h00, 3'h6, 8'h05);
		idle(1);
		audio_in <= '{8'hEC, 1'b0};
		idle(3);
		aq(8'h01, 3'h6, 8'hEC);
		aq(8'h00, 3'h0, 8'hEC);
	endtask
	task automatic t_tune();
		logic [7:0] e [8];
		e = '{8'h00, 8'h1A, 8'h2B, 8'h00, 8'h73, 8'h2F, 8'h11, 8'h00};
		idle(1);
		tune_info <= '{16'h1A2B, 8'h73, 8'h2F, 8'h11, 1'b1};
		tune_done <= 1'b1;
		i_host.bus(1'b1, 1'b0, ADDR_IEN, 8'h01);
		tune_done <= 1'b0;
		idle(3);
		chk_irq("tune irq", 1'b1);
		i_host.get(ADDR_STATUS, st);
		chk("tune irq st", 8'h81, st & 8'hC1);
		i_host.cmd(OPC_TUNE_STATUS, 8'h01, st);
		chk("tune ack", 8'h80, st & 8'hC1);
		chk_irq("tune irq clr", 1'b0);
		for (int i = 0; i < 8; i++) begin
			i_host.get(ADDR_RESP, b);
			if (i != 0 && i != 3) chk("tune byte", e[i], b);
		end
		tune_info.noise_valid <= 1'b0;
		i_host.cmd(OPC_TUNE_STATUS, 8'h00, st);
		repeat (7) i_host.get(ADDR_RESP, b);
		chk("tune noise", 8'h00, b);
	endtask
	task automatic t_err();
		i_host.cmd(OPC_AQ_STATUS, 8'h02, st);
		chk("bad arg err", 8'hC0, st & 8'hC0);
		i_host.get(ADDR_RESP, b);
		chk("bad arg reply", 8'h00, b);
		i_host.bus(1'b1, 1'b0, ADDR_CMD, 8'h00);
		i_host.get(ADDR_STATUS, st);
		chk("bad opcode", 8'hC0, st & 8'hC0);
		i_host.bus(1'b1, 1'b0, ADDR_CMD, OPC_AQ_STATUS);
		i_host.cmd(OPC_TUNE_STATUS, 8'h00, st);
		repeat (5) i_host.get(ADDR_RESP, b);
		chk("refused cmd", 8'h00, b);
		idle(1);
		powered_up <= 1'b0;
		i_host.bus(1'b1, 1'b0, ADDR_CMD, OPC_AQ_STATUS);
		i_host.get(ADDR_STATUS, st);
		chk("power err", 8'hC0, st & 8'hC0);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		t_arm();
		t_low();
		t_high();
		t_tune();
		t_err();
		complete_run();
	end
endmodule
bind tx_status_block tx_status_checker i_chk(.clk(clk), .resetn(resetn),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.powered_up(powered_up), .irq_out(irq_out));
